// ===== rtl/graphics_interrupt_params.svh
// Offsets, field positions and reset values of the interrupt unit.
// Assumes inclusion by bare name from the design files.
`ifndef GRAPHICS_INTERRUPT_PARAMS_SVH
`define GRAPHICS_INTERRUPT_PARAMS_SVH

// Register byte offsets
`define OFS_STATUS    8'h00
`define OFS_ENABLE    8'h04
`define OFS_CLEAR     8'h08
`define OFS_SYNC_END  8'h0c
`define OFS_LINE_CMP  8'h10

// Field positions in status; enable uses pick, vline and ext, clear pick and vline
`define BIT_PICK      2
`define BIT_VSYNC_LVL 3
`define BIT_VSYNC     4
`define BIT_VLINE     5
`define BIT_EXT       6

// Field positions in the sync end control register
`define BIT_VSYNC_CLR 4
`define BIT_VSYNC_EN  5

// Reset values
`define RST_ENABLE    3'h0
`define RST_SYNC_END  8'h00

`endif

// ===== rtl/graphics_interrupt_pkg.sv
// Types shared by the interrupt unit files.
// Assumes the params header supplies the register offsets, field positions and reset values.
package graphics_interrupt_pkg;
	typedef logic [7:0]  addr_t;
	typedef logic [31:0] word_t;
	typedef enum {
		SEL_STATUS,
		SEL_ENABLE,
		SEL_CLEAR,
		SEL_SYNC_END,
		SEL_LINE_CMP,
		SEL_NONE
	} reg_sel_e;
endpackage

// ===== rtl/irq_flag_if.sv
// Carrier for one sticky pending flag: set, clear and the flag itself.
// Assumes one owner drives the flag and one user drives set and clear.
`timescale 1ns/1ns
interface irq_flag_if;
	logic set;
	logic clr;
	logic pend;
	modport owner (input set, input clr, output pend);
	modport user  (output set, output clr, input pend);
endinterface

// ===== rtl/pin_sync_edge.sv
// Two-flop synchroniser for a pin with a rising edge detector.
// Assumes the pin is asynchronous to clk; edge logic reads stage two only.
`timescale 1ns/1ns
module pin_sync_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin side
	input  wire logic pin,
	// Synchronised side
	output logic      level,
	output logic      rise
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
endmodule

// ===== rtl/irq_flag.sv
// One sticky pending flag; a set in the clear cycle wins.
// Assumes set and clr are one-cycle pulses on clk.
`timescale 1ns/1ns
module irq_flag (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Flag carrier
	irq_flag_if.owner f
);
	logic pend_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else if (f.set) begin
			pend_q <= 1'b1;
		end else if (f.clr) begin
			pend_q <= 1'b0;
		end
	end

	assign f.pend = pend_q;
endmodule

// ===== rtl/graphics_interrupt_unit.sv
// Interrupt collector of the graphics accelerator: pick, vertical sync,
// vertical line and external sources onto one active-low host line.
// Assumes vcount and line_start come from video timing on clk, pick
// strobes from the drawing engine on clk, vsync and ext_irq from pins.
`timescale 1ns/1ns
`include "graphics_interrupt_params.svh"
module graphics_interrupt_unit #(
	parameter int LINE_W = 11
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Register port
	input  wire graphics_interrupt_pkg::addr_t addr,
	input  wire graphics_interrupt_pkg::word_t wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output graphics_interrupt_pkg::word_t   rdata,
	// Video timing
	input  wire logic                       vsync,
	input  wire logic [LINE_W-1:0]          vcount,
	input  wire logic                       line_start,
	// Drawing engine
	input  wire logic                       pick_pixel,
	input  wire logic                       pick_atype_ok,
	// External device
	input  wire logic                       ext_irq,
	// Host
	output logic                            host_irq_n
);
	localparam int NSRC = 3;
	localparam int IX_PICK = 0;
	localparam int IX_VSYNC = 1;
	localparam int IX_VLINE = 2;

	graphics_interrupt_pkg::word_t rdata_q;
	logic [2:0]                    source_enable_reg_q;
	logic [7:0]                    sync_end_control_reg_q;
	logic [LINE_W-1:0]             line_compare_reg_q;
	logic                          host_irq_n_q;
	logic                          vsync_lvl;
	logic                          vsync_rise;
	logic                          ext_lvl;
	logic                          vsync_irq_en;
	logic [NSRC-1:0]               set_vec;
	logic [NSRC-1:0]               clr_vec;
	logic [NSRC-1:0]               pend_vec;
	logic                          irq_any;
	logic                          wr_clear;
	logic                          wr_sync;
	graphics_interrupt_pkg::reg_sel_e wsel;
	graphics_interrupt_pkg::reg_sel_e rsel;

	// Address decode, shared by the write and read paths
	function automatic graphics_interrupt_pkg::reg_sel_e decode(
		input graphics_interrupt_pkg::addr_t a
	);
		case (a)
			`OFS_STATUS:   decode = graphics_interrupt_pkg::SEL_STATUS;
			`OFS_ENABLE:   decode = graphics_interrupt_pkg::SEL_ENABLE;
			`OFS_CLEAR:    decode = graphics_interrupt_pkg::SEL_CLEAR;
			`OFS_SYNC_END: decode = graphics_interrupt_pkg::SEL_SYNC_END;
			`OFS_LINE_CMP: decode = graphics_interrupt_pkg::SEL_LINE_CMP;
			default:       decode = graphics_interrupt_pkg::SEL_NONE;
		endcase
	endfunction

	assign wsel = decode(addr);
	assign rsel = decode(addr);

	// Pin inputs
	pin_sync_edge u_vsync_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (vsync),
		.level (vsync_lvl),
		.rise  (vsync_rise)
	);

	pin_sync_edge u_ext_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (ext_irq),
		.level (ext_lvl),
		.rise  ()
	);

	assign vsync_irq_en = sync_end_control_reg_q[`BIT_VSYNC_EN];
	assign wr_clear     = wr && (wsel == graphics_interrupt_pkg::SEL_CLEAR);
	assign wr_sync      = wr && (wsel == graphics_interrupt_pkg::SEL_SYNC_END);

	// Event sources
	assign set_vec[IX_PICK]  = pick_pixel & pick_atype_ok;
	assign set_vec[IX_VSYNC] = vsync_rise & vsync_irq_en;
	assign set_vec[IX_VLINE] = line_start && (vcount == line_compare_reg_q);

	// Clears are write-one; a zero bit leaves the flag alone
	assign clr_vec[IX_PICK]  = wr_clear & wdata[`BIT_PICK];
	assign clr_vec[IX_VSYNC] = wr_sync & wdata[`BIT_VSYNC_CLR];
	assign clr_vec[IX_VLINE] = wr_clear & wdata[`BIT_VLINE];

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_flag
			irq_flag_if fi ();
			assign fi.set = set_vec[gi];
			assign fi.clr = clr_vec[gi];
			assign pend_vec[gi] = fi.pend;
			irq_flag u_flag (
				.clk (clk),
				.rst (rst),
				.f   (fi)
			);
		end
	endgenerate

	// Enable register; writes touch no flag
	always_ff @(posedge clk) begin
		if (rst) begin
			source_enable_reg_q <= `RST_ENABLE;
		end else if (wr && (wsel == graphics_interrupt_pkg::SEL_ENABLE)) begin
			source_enable_reg_q <= {wdata[`BIT_EXT], wdata[`BIT_VLINE], wdata[`BIT_PICK]};
		end
	end

	// Sync end control; the clear bit is not stored so it reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_end_control_reg_q <= `RST_SYNC_END;
		end else if (wr_sync) begin
			sync_end_control_reg_q <= wdata[7:0] & ~(8'h01 << `BIT_VSYNC_CLR);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			line_compare_reg_q <= '0;
		end else if (wr && (wsel == graphics_interrupt_pkg::SEL_LINE_CMP)) begin
			line_compare_reg_q <= wdata[LINE_W-1:0];
		end
	end

	// Host line. External level has no flag: the far device owns its clear.
	assign irq_any = (pend_vec[IX_PICK] & source_enable_reg_q[0])
		| (pend_vec[IX_VSYNC] & vsync_irq_en)
		| (pend_vec[IX_VLINE] & source_enable_reg_q[1])
		| (ext_lvl & source_enable_reg_q[2]);

	// Registered so the pin never glitches on decode hazards
	always_ff @(posedge clk) begin
		if (rst) begin
			host_irq_n_q <= 1'b1;
		end else begin
			host_irq_n_q <= ~irq_any;
		end
	end

	assign host_irq_n = host_irq_n_q;

	// Read path; unmapped and clear offsets read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd) begin
			rdata_q <= 32'h0000_0000;
			case (rsel)
				graphics_interrupt_pkg::SEL_STATUS: begin
					rdata_q[`BIT_PICK]      <= pend_vec[IX_PICK];
					rdata_q[`BIT_VSYNC_LVL] <= vsync_lvl;
					rdata_q[`BIT_VSYNC]     <= pend_vec[IX_VSYNC];
					rdata_q[`BIT_VLINE]     <= pend_vec[IX_VLINE];
					rdata_q[`BIT_EXT]       <= ext_lvl;
				end
				graphics_interrupt_pkg::SEL_ENABLE: begin
					rdata_q[`BIT_PICK]  <= source_enable_reg_q[0];
					rdata_q[`BIT_VLINE] <= source_enable_reg_q[1];
					rdata_q[`BIT_EXT]   <= source_enable_reg_q[2];
				end
				graphics_interrupt_pkg::SEL_SYNC_END: begin
					rdata_q[7:0] <= sync_end_control_reg_q;
				end
				graphics_interrupt_pkg::SEL_LINE_CMP: begin
					rdata_q[LINE_W-1:0] <= line_compare_reg_q;
				end
				default: begin
					rdata_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign rdata = rdata_q;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_VSYNC_SET: assert property (
		vsync_rise && vsync_irq_en |=> pend_vec[IX_VSYNC]
	) else $error("vsync edge with enable did not set pending");

	AST_VSYNC_GATED: assert property (
		!pend_vec[IX_VSYNC] && !vsync_irq_en |=> !pend_vec[IX_VSYNC]
	) else $error("vsync pending rose while disabled");

	AST_VSYNC_EN_BIT: assert property (
		wr_sync |=> vsync_irq_en == $past(wdata[`BIT_VSYNC_EN])
			&& !sync_end_control_reg_q[`BIT_VSYNC_CLR]
	) else $error("sync end control bits wrong after write");

	AST_VSYNC_CLR: assert property (
		wr_sync && wdata[`BIT_VSYNC_CLR] && !set_vec[IX_VSYNC] |=> !pend_vec[IX_VSYNC]
	) else $error("vsync clear bit ignored");

	AST_VSYNC_FROM_EDGE: assert property (
		$rose(pend_vec[IX_VSYNC]) |-> $past(vsync_rise && vsync_irq_en)
	) else $error("vsync pending set without an enabled edge");

	AST_VSYNC_HOLD: assert property (
		pend_vec[IX_VSYNC] && !clr_vec[IX_VSYNC] |=> pend_vec[IX_VSYNC]
	) else $error("vsync pending dropped without clear");

	AST_SYNC_CLR_RD: assert property (
		rd && rsel == graphics_interrupt_pkg::SEL_SYNC_END |=> !rdata[`BIT_VSYNC_CLR]
	) else $error("vsync clear bit read back nonzero");

	AST_VLINE_SET: assert property (
		line_start && vcount == line_compare_reg_q |=> pend_vec[IX_VLINE]
	) else $error("line match did not set pending");

	AST_VLINE_AT_START: assert property (
		$rose(pend_vec[IX_VLINE]) |-> $past(line_start)
	) else $error("line pending set away from line start");

	AST_PICK_SET: assert property (
		pick_pixel && pick_atype_ok |=> pend_vec[IX_PICK]
	) else $error("pick pixel did not set pending");

	AST_PICK_ATYPE: assert property (
		$rose(pend_vec[IX_PICK]) |-> $past(pick_atype_ok) && $past(pick_pixel)
	) else $error("pick pending without picking access type");

	AST_HOLD: assert property (
		pend_vec[IX_VLINE] && !clr_vec[IX_VLINE] |=> pend_vec[IX_VLINE]
	) else $error("line pending dropped without clear");

	AST_CLEAR_ONE: assert property (
		wr_clear && wdata[`BIT_PICK] && !set_vec[IX_PICK] |=> !pend_vec[IX_PICK]
	) else $error("write one did not clear pick");

	AST_CLEAR_ZERO: assert property (
		wr_clear && !wdata[`BIT_VLINE] && pend_vec[IX_VLINE] |=> pend_vec[IX_VLINE]
	) else $error("write zero cleared line pending");

	AST_CLEAR_READS_ZERO: assert property (
		rd && rsel == graphics_interrupt_pkg::SEL_CLEAR |=> rdata == 32'h0000_0000
	) else $error("clear register read nonzero");

	AST_ENABLE_NO_FLAG: assert property (
		wr && wsel == graphics_interrupt_pkg::SEL_ENABLE && set_vec == '0
			|=> pend_vec == $past(pend_vec)
	) else $error("enable write changed a flag");

	AST_STATUS_PEND: assert property (
		rd && rsel == graphics_interrupt_pkg::SEL_STATUS
			|=> rdata[`BIT_PICK] == $past(pend_vec[IX_PICK])
			&& rdata[`BIT_VSYNC] == $past(pend_vec[IX_VSYNC])
			&& rdata[`BIT_VLINE] == $past(pend_vec[IX_VLINE])
	) else $error("status pending bits wrong");

	AST_STATUS_LIVE: assert property (
		rd && rsel == graphics_interrupt_pkg::SEL_STATUS
			|=> rdata[`BIT_VSYNC_LVL] == $past(vsync_lvl)
			&& rdata[`BIT_EXT] == $past(ext_lvl)
	) else $error("status live bits wrong");

	AST_IRQ_ON: assert property (
		pend_vec[IX_PICK] && source_enable_reg_q[0] |=> !host_irq_n
	) else $error("enabled pick did not assert host line");

	AST_IRQ_OFF: assert property (
		!irq_any |=> host_irq_n
	) else $error("host line low with nothing enabled");

	AST_EXT_LEVEL: assert property (
		ext_lvl && source_enable_reg_q[2] ##1 ext_lvl && source_enable_reg_q[2]
			|-> !host_irq_n
	) else $error("external level not forwarded");

	AST_VLINE_ONLY_MATCH: assert property (
		$rose(pend_vec[IX_VLINE]) |-> $past(vcount == line_compare_reg_q)
	) else $error("line pending set without a count match");

	AST_LINE_CMP_WR: assert property (
		wr && wsel == graphics_interrupt_pkg::SEL_LINE_CMP
			|=> line_compare_reg_q == $past(wdata[LINE_W-1:0])
	) else $error("line compare write not stored");

	AST_VLINE_CLR: assert property (
		wr_clear && wdata[`BIT_VLINE] && !set_vec[IX_VLINE] |=> !pend_vec[IX_VLINE]
	) else $error("write one did not clear line pending");

	AST_PICK_HOLD: assert property (
		pend_vec[IX_PICK] && !clr_vec[IX_PICK] |=> pend_vec[IX_PICK]
	) else $error("pick pending dropped without clear");

	AST_SET_WINS: assert property (
		set_vec[IX_PICK] && clr_vec[IX_PICK] |=> pend_vec[IX_PICK]
	) else $error("clear beat a pick in the same cycle");

	AST_IRQ_VLINE: assert property (
		pend_vec[IX_VLINE] && source_enable_reg_q[1] |=> !host_irq_n
	) else $error("enabled line pending did not assert host line");

	AST_IRQ_VSYNC: assert property (
		pend_vec[IX_VSYNC] && vsync_irq_en |=> !host_irq_n
	) else $error("enabled vsync pending did not assert host line");

	AST_IRQ_NEEDS_EN: assert property (
		source_enable_reg_q == 3'h0 && !vsync_irq_en
			##1 source_enable_reg_q == 3'h0 && !vsync_irq_en |-> host_irq_n
	) else $error("host line low with every enable off");

	AST_ENABLE_RB: assert property (
		rd && rsel == graphics_interrupt_pkg::SEL_ENABLE
			|=> rdata[`BIT_PICK] == $past(source_enable_reg_q[0])
			&& rdata[`BIT_VLINE] == $past(source_enable_reg_q[1])
			&& rdata[`BIT_EXT] == $past(source_enable_reg_q[2])
	) else $error("enable read back wrong");

	COV_VSYNC: cover property (vsync_rise && vsync_irq_en ##1 !host_irq_n);
	COV_VLINE: cover property (set_vec[IX_VLINE] ##[1:20] clr_vec[IX_VLINE]);
	COV_PICK:  cover property (set_vec[IX_PICK] && clr_vec[IX_PICK]);
	COV_EXT:   cover property ($rose(ext_lvl) ##[1:10] $fell(ext_lvl));
	COV_EXT_IRQ: cover property (ext_lvl && source_enable_reg_q[2] ##1 !host_irq_n);
endmodule

// ===== sim/ext_device_model.sv
// Behavioural external device that drives the external interrupt pin.
// Assumes the bench pulses raise and clear for one clk cycle each.
`timescale 1ns/1ns
module ext_device_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Bench control
	input  wire logic raise,
	input  wire logic clear,
	input  wire logic enable,
	// Pin
	output logic      irq
);
	logic pend_q;

	// The device keeps its own pending flag, clear and enable
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			pend_q <= 1'b0;
		end else if (raise) begin
			pend_q <= 1'b1;
		end
	end

	assign irq = pend_q & enable;
endmodule

// ===== sim/tb_graphics_interrupt_unit.sv
// Self-checking bench for the interrupt unit, register port driven by tasks.
// Assumes the unit's contract: read data one cycle after rd, pins 2-flop synced.
`timescale 1ns/1ns
`include "graphics_interrupt_params.svh"
module tb_graphics_interrupt_unit;
	logic                          clk, rst, wr, rd, vsync, line_start;
	logic                          pick_pixel, pick_atype_ok, ext_irq, host_irq_n;
	logic                          x_raise, x_clear, x_en;
	logic [10:0]                   vcount;
	graphics_interrupt_pkg::addr_t addr;
	graphics_interrupt_pkg::word_t wdata, rdata;
	int                            n_errors, comparisons, cycles;

	graphics_interrupt_unit #(.LINE_W(11)) i_graphics_interrupt_unit (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .vsync(vsync), .vcount(vcount), .line_start(line_start),
		.pick_pixel(pick_pixel), .pick_atype_ok(pick_atype_ok), .ext_irq(ext_irq),
		.host_irq_n(host_irq_n));

	ext_device_model i_ext_device_model (
		.clk(clk), .rst(rst), .raise(x_raise), .clear(x_clear), .enable(x_en),
		.irq(ext_irq));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic give_verdict();
		$display("Errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs about two hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data appear in the cycle after the strobe and hold until the next read; sample there
	task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask

	// Registered host line lags its cause; four cycles cover pin sync too
	task automatic host_chk(logic exp);
		repeat (4) @(posedge clk);
		#1;
		chk("host_irq_n", {31'h0, exp}, {31'h0, host_irq_n});
	endtask

	task automatic pick(logic ok);
		@(posedge clk);
		pick_pixel <= 1'b1;
		pick_atype_ok <= ok;
		@(posedge clk);
		pick_pixel <= 1'b0;
	endtask

	task automatic vsync_set(logic v);
		@(posedge clk);
		vsync <= v;
		repeat (5) @(posedge clk);
	endtask

	task automatic line_evt(logic [10:0] v, logic st);
		@(posedge clk);
		vcount <= v;
		line_start <= st;
		@(posedge clk);
		line_start <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Far device raise or clear, one cycle, launched on a rising edge
	task automatic ext_pulse(logic r, logic c);
		@(posedge clk);
		x_raise <= r;
		x_clear <= c;
		@(posedge clk);
		x_raise <= 1'b0;
		x_clear <= 1'b0;
	endtask

	initial begin
		{rst, wr, rd, vsync, line_start, pick_pixel, pick_atype_ok} = 7'h40;
		{x_raise, x_clear, x_en} = 3'h0;
		vcount = 11'h000;
		addr = 8'h00;
		wdata = 32'h0;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unmapped place
		rd_chk("status", `OFS_STATUS, 32'h0);
		rd_chk("enable", `OFS_ENABLE, 32'h0);
		rd_chk("sync_end", `OFS_SYNC_END, 32'h0);
		rd_chk("unmapped", 8'h14, 32'h0);
		host_chk(1'b1);
		// Pick: wrong access type is ignored, then a real pick while disabled
		pick(1'b0);
		rd_chk("pick_off", `OFS_STATUS, 32'h0);
		pick(1'b1);
		rd_chk("pick_pend", `OFS_STATUS, 32'h04);
		host_chk(1'b1);
		wr_reg(`OFS_ENABLE, 32'h04);
		host_chk(1'b0);
		rd_chk("pick_kept", `OFS_STATUS, 32'h04);
		wr_reg(`OFS_CLEAR, 32'h0);
		rd_chk("clear_zero", `OFS_STATUS, 32'h04);
		rd_chk("clear_reads", `OFS_CLEAR, 32'h0);
		wr_reg(`OFS_CLEAR, 32'h04);
		rd_chk("pick_clr", `OFS_STATUS, 32'h0);
		host_chk(1'b1);
		// Pick in the very cycle of its clear write: the set wins
		@(posedge clk);
		pick_pixel <= 1'b1;
		wr <= 1'b1;
		addr <= `OFS_CLEAR;
		wdata <= 32'h04;
		@(posedge clk);
		pick_pixel <= 1'b0;
		wr <= 1'b0;
		rd_chk("pick_wins", `OFS_STATUS, 32'h04);
		host_chk(1'b0);
		wr_reg(`OFS_CLEAR, 32'h04);
		rd_chk("pick_clr2", `OFS_STATUS, 32'h0);
		// Vsync: edge dropped while disabled, live level still shown
		vsync_set(1'b1);
		rd_chk("vs_level", `OFS_STATUS, 32'h08);
		vsync_set(1'b0);
		rd_chk("vs_dropped", `OFS_STATUS, 32'h0);
		wr_reg(`OFS_SYNC_END, 32'h20);
		vsync_set(1'b1);
		rd_chk("vs_pend", `OFS_STATUS, 32'h18);
		host_chk(1'b0);
		vsync_set(1'b0);
		wr_reg(`OFS_SYNC_END, 32'h30);
		rd_chk("vs_clr", `OFS_STATUS, 32'h0);
		rd_chk("sync_end_rb", `OFS_SYNC_END, 32'h20);
		wr_reg(`OFS_SYNC_END, 32'h0);
		// Vertical line: only a matching count at a line start counts
		wr_reg(`OFS_LINE_CMP, 32'h5);
		rd_chk("line_cmp_rb", `OFS_LINE_CMP, 32'h5);
		line_evt(11'h004, 1'b1);
		line_evt(11'h005, 1'b0);
		rd_chk("line_none", `OFS_STATUS, 32'h0);
		line_evt(11'h005, 1'b1);
		rd_chk("line_pend", `OFS_STATUS, 32'h20);
		wr_reg(`OFS_CLEAR, 32'h20);
		wr_reg(`OFS_ENABLE, 32'h20);
		host_chk(1'b1);
		line_evt(11'h005, 1'b1);
		host_chk(1'b0);
		wr_reg(`OFS_ENABLE, 32'h0);
		host_chk(1'b1);
		rd_chk("line_kept", `OFS_STATUS, 32'h20);
		wr_reg(`OFS_CLEAR, 32'h20);
		// External: level only, the device clears itself
		x_en <= 1'b1;
		ext_pulse(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		rd_chk("ext_level", `OFS_STATUS, 32'h40);
		host_chk(1'b1);
		wr_reg(`OFS_ENABLE, 32'h40);
		host_chk(1'b0);
		ext_pulse(1'b0, 1'b1);
		host_chk(1'b1);
		rd_chk("ext_gone", `OFS_STATUS, 32'h0);
		give_verdict();
	end
endmodule
